/* shared/frame_filter_pkg.sv */
// Constants shared by the frame address filter register bank
`default_nettype none
package frame_filter_pkg;
  // Register offsets on the serial control port
  localparam logic [7:0] OFS_FILTER_EN  = 8'h00;
  localparam logic [7:0] OFS_MODE_CFG   = 8'h01;
  localparam logic [7:0] OFS_TYPE_MASK  = 8'h02;
  localparam logic [7:0] OFS_VER_MASK   = 8'h03;
  localparam logic [7:0] OFS_STATUS     = 8'h04;
  localparam logic [7:0] OFS_AUTO_MODE  = 8'h1d;
  localparam int         EXT_BASE       = 32'h05;
  localparam int         EXT_BYTES      = 8;
  localparam int         UNIT_BASE      = 32'h0d;
  localparam int         UNIT_STRIDE    = 4;
  localparam int         PAN_LO_OFS     = 0;
  localparam int         PAN_HI_OFS     = 1;
  localparam int         SHORT_LO_OFS   = 2;
  localparam int         SHORT_HI_OFS   = 3;
  localparam int         MAX_UNITS      = 4;
  // Field positions
  localparam int         MAP_LSB        = 4;
  localparam int         COORD_LSB      = 0;
  localparam int         EXT_MATCH_BIT  = 4;
  localparam int         ACK_SENT_BIT   = 7;
  localparam int         FCS_ADAPT_BIT  = 6;
  localparam int         AUTO_ACK_BIT   = 3;
  // Software-writable bits of the auto mode control register
  localparam logic [7:0] AUTO_RW_MASK   = 8'h7b;
  // Reset values
  localparam logic [7:0] TYPE_MASK_RST  = 8'h0b;
  localparam logic [3:0] VER_MASK_RST   = 4'h3;
  localparam logic [7:0] BYTE_RST       = 8'h00;
  // Frame control encodings
  localparam logic [2:0] FT_BEACON      = 3'h0;
  localparam logic [2:0] FT_DATA        = 3'h1;
  localparam logic [2:0] FT_CMD         = 3'h3;
  localparam logic [2:0] FT_RSV_MIN     = 3'h4;
  localparam logic [1:0] AM_NONE        = 2'h0;
  localparam logic [1:0] AM_SHORT       = 2'h2;
  localparam logic [1:0] AM_EXT         = 2'h3;
  localparam logic [15:0] BCAST_ID      = 16'hffff;
  // Checksum type: 1 selects the 16-bit checksum
  localparam logic       FCS_TYPE_16    = 1'b1;
  localparam logic [2:0] ACK_LEN_FCS16  = 3'h5;
  localparam logic [2:0] ACK_LEN_FCS32  = 3'h7;
endpackage
`default_nettype wire

/* shared/filter_unit_if.sv */
// Configuration, frame fields and match result of one filter unit
`default_nettype none
interface filter_unit_if;
  logic        enable;
  logic        coordinator;
  logic        map_reserved;
  logic        global_pass;
  logic [15:0] pan_id;
  logic [15:0] short_addr;
  logic [63:0] ext_addr;
  logic [2:0]  frame_type;
  logic [1:0]  dst_mode;
  logic [15:0] dst_pan;
  logic [15:0] dst_short;
  logic [63:0] dst_ext;
  logic [15:0] src_pan;
  logic        match;
  modport ctrl (output enable, coordinator, map_reserved, global_pass, pan_id, short_addr,
                output ext_addr, frame_type, dst_mode, dst_pan, dst_short, dst_ext, src_pan,
                input match);
  modport unit (input enable, coordinator, map_reserved, global_pass, pan_id, short_addr,
                input ext_addr, frame_type, dst_mode, dst_pan, dst_short, dst_ext, src_pan,
                output match);
endinterface
`default_nettype wire

/* verilog/filter_unit.sv */
// Third-level address filter unit: decides an address match for one unit
`default_nettype none
module filter_unit
  import frame_filter_pkg::*;
(
  // Configuration and frame fields
  filter_unit_if.unit port
);
  logic [2:0] eff_type;
  logic       rsv_drop;
  logic       pan_ok;
  logic       hit;

  always_comb begin
    eff_type = port.frame_type;
    rsv_drop = 1'b0;
    if (port.frame_type >= FT_RSV_MIN) begin
      if (port.map_reserved) begin
        eff_type = FT_DATA;
      end else begin
        rsv_drop = 1'b1;
      end
    end
    pan_ok = (port.dst_pan == port.pan_id) || (port.dst_pan == BCAST_ID);
    case (port.dst_mode)
      AM_SHORT: hit = pan_ok && ((port.dst_short == port.short_addr) || (port.dst_short == BCAST_ID));
      AM_EXT:   hit = pan_ok && (port.dst_ext == port.ext_addr);
      AM_NONE: begin
        if (eff_type == FT_BEACON) begin
          hit = (port.src_pan == port.pan_id) || (port.pan_id == BCAST_ID);
        end else begin
          hit = port.coordinator && ((eff_type == FT_DATA) || (eff_type == FT_CMD)) &&
                (port.src_pan == port.pan_id);
        end
      end
      default:  hit = 1'b0;
    endcase
  end

  assign port.match = port.enable && port.global_pass && !rsv_drop && hit;
endmodule
`default_nettype wire

/* verilog/frame_address_filter_regs.sv */
// Frame address filter registers, match status and auto-acknowledge control
`default_nettype none
module frame_address_filter_regs
  import frame_filter_pkg::*;
#(
  parameter int NUM_UNITS = MAX_UNITS
) (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        resetn_in,
  // Register port of the serial control interface
  input  wire logic [7:0]  cfg_addr_in,
  input  wire logic [7:0]  cfg_wdata_in,
  input  wire logic        cfg_write_in,
  input  wire logic        cfg_read_in,
  output logic      [7:0]  cfg_rdata_out,
  output logic             cfg_rvalid_out,
  // Received frame events and fields
  input  wire logic        rx_frame_start_irq_in,
  input  wire logic        rx_hdr_valid_in,
  input  wire logic        rx_frame_end_irq_in,
  input  wire logic [2:0]  rx_frame_type_in,
  input  wire logic [1:0]  rx_frame_version_in,
  input  wire logic [1:0]  rx_dst_mode_in,
  input  wire logic [15:0] rx_dst_pan_in,
  input  wire logic [15:0] rx_dst_short_in,
  input  wire logic [63:0] rx_dst_ext_in,
  input  wire logic [15:0] rx_src_pan_in,
  input  wire logic        rx_ack_request_in,
  input  wire logic        rx_fcs_type_in,
  input  wire logic        checksum_type_setting_in,
  // Filter and acknowledge results
  output logic             frame_accept_out,
  output logic             ack_checksum_type_out,
  output logic      [2:0]  ack_length_out
);
  generate
    if (NUM_UNITS < 1 || NUM_UNITS > MAX_UNITS) begin : g_bad
      $error("NUM_UNITS must lie between 1 and 4");
    end
  endgenerate

  logic [NUM_UNITS-1:0] filter_unit_enable;
  logic [7:0]           filter_unit_mode_cfg;
  logic [7:0]           frame_type_mask;
  logic [3:0]           frame_version_mask;
  logic [4:0]           filter_match_status;
  logic [63:0]          ext_address;
  logic [15:0]          pan_id [NUM_UNITS];
  logic [15:0]          short_addr [NUM_UNITS];
  logic [7:0]           auto_mode_control;
  logic                 frame_accept;

  logic [NUM_UNITS-1:0] next_filter_unit_enable;
  logic [7:0]           next_filter_unit_mode_cfg;
  logic [7:0]           next_frame_type_mask;
  logic [3:0]           next_frame_version_mask;
  logic [4:0]           next_filter_match_status;
  logic [63:0]          next_ext_address;
  logic [15:0]          next_pan_id [NUM_UNITS];
  logic [15:0]          next_short_addr [NUM_UNITS];
  logic [7:0]           next_auto_mode_control;
  logic                 next_frame_accept;
  logic [7:0]           next_rdata;
  logic                 next_ack_type;

  logic                 global_pass;
  logic                 ext_match;
  logic [NUM_UNITS-1:0] unit_match;

  assign global_pass = frame_type_mask[rx_frame_type_in] && frame_version_mask[rx_frame_version_in];

  // Extended filter runs while any unit is enabled
  assign ext_match = (|filter_unit_enable) && global_pass && (rx_dst_mode_in == AM_EXT) &&
                     (rx_dst_ext_in == ext_address);

  filter_unit_if u_if[NUM_UNITS] ();

  generate
    for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
      assign u_if[u].enable       = filter_unit_enable[u];
      assign u_if[u].coordinator  = filter_unit_mode_cfg[COORD_LSB + u];
      assign u_if[u].map_reserved = filter_unit_mode_cfg[MAP_LSB + u];
      assign u_if[u].global_pass  = global_pass;
      assign u_if[u].pan_id       = pan_id[u];
      assign u_if[u].short_addr   = short_addr[u];
      assign u_if[u].ext_addr     = ext_address;
      assign u_if[u].frame_type   = rx_frame_type_in;
      assign u_if[u].dst_mode     = rx_dst_mode_in;
      assign u_if[u].dst_pan      = rx_dst_pan_in;
      assign u_if[u].dst_short    = rx_dst_short_in;
      assign u_if[u].dst_ext      = rx_dst_ext_in;
      assign u_if[u].src_pan      = rx_src_pan_in;
      assign unit_match[u]        = u_if[u].match;
      filter_unit u_unit (
        .port (u_if[u])
      );
    end
  endgenerate

  // Software writes to configuration registers
  always_comb begin
    next_filter_unit_enable   = filter_unit_enable;
    next_filter_unit_mode_cfg = filter_unit_mode_cfg;
    next_frame_type_mask      = frame_type_mask;
    next_frame_version_mask   = frame_version_mask;
    next_ext_address          = ext_address;
    next_pan_id               = pan_id;
    next_short_addr           = short_addr;
    next_auto_mode_control    = auto_mode_control;
    if (cfg_write_in) begin
      case (cfg_addr_in)
        OFS_FILTER_EN: next_filter_unit_enable   = cfg_wdata_in[NUM_UNITS-1:0];
        OFS_MODE_CFG:  next_filter_unit_mode_cfg = cfg_wdata_in;
        OFS_TYPE_MASK: next_frame_type_mask      = cfg_wdata_in;
        OFS_VER_MASK:  next_frame_version_mask   = cfg_wdata_in[3:0];
        OFS_AUTO_MODE: next_auto_mode_control    = (auto_mode_control & ~AUTO_RW_MASK) |
                                                   (cfg_wdata_in & AUTO_RW_MASK);
        default: ;
      endcase
      // Byte k carries address bits 8k+7..8k
      for (int k = 0; k < EXT_BYTES; k++) begin
        if (cfg_addr_in == 8'(EXT_BASE + k)) begin
          next_ext_address[8*k +: 8] = cfg_wdata_in;
        end
      end
      for (int u = 0; u < NUM_UNITS; u++) begin
        if (cfg_addr_in == 8'(UNIT_BASE + UNIT_STRIDE*u + PAN_LO_OFS)) begin
          next_pan_id[u][7:0] = cfg_wdata_in;
        end
        if (cfg_addr_in == 8'(UNIT_BASE + UNIT_STRIDE*u + PAN_HI_OFS)) begin
          next_pan_id[u][15:8] = cfg_wdata_in;
        end
        if (cfg_addr_in == 8'(UNIT_BASE + UNIT_STRIDE*u + SHORT_LO_OFS)) begin
          next_short_addr[u][7:0] = cfg_wdata_in;
        end
        if (cfg_addr_in == 8'(UNIT_BASE + UNIT_STRIDE*u + SHORT_HI_OFS)) begin
          next_short_addr[u][15:8] = cfg_wdata_in;
        end
      end
    end
    // Flag reflects whether an ACK went out
    // Updated only at frame end under auto-ack
    if (rx_frame_end_irq_in && auto_mode_control[AUTO_ACK_BIT]) begin
      next_auto_mode_control[ACK_SENT_BIT] = frame_accept && rx_ack_request_in;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      filter_unit_enable   <= '0;
      filter_unit_mode_cfg <= BYTE_RST;
      frame_type_mask      <= TYPE_MASK_RST;
      frame_version_mask   <= VER_MASK_RST;
      ext_address          <= '0;
      pan_id               <= '{default: '0};
      short_addr           <= '{default: '0};
      auto_mode_control    <= BYTE_RST;
    end else begin
      filter_unit_enable   <= next_filter_unit_enable;
      filter_unit_mode_cfg <= next_filter_unit_mode_cfg;
      frame_type_mask      <= next_frame_type_mask;
      frame_version_mask   <= next_frame_version_mask;
      ext_address          <= next_ext_address;
      pan_id               <= next_pan_id;
      short_addr           <= next_short_addr;
      auto_mode_control    <= next_auto_mode_control;
    end
  end

  // Match status: a match in the start cycle survives the clear
  always_comb begin
    next_filter_match_status = filter_match_status;
    next_frame_accept        = frame_accept;
    if (rx_frame_start_irq_in) begin
      next_filter_match_status = '0;
      next_frame_accept        = 1'b0;
    end
    if (rx_hdr_valid_in) begin
      next_filter_match_status[NUM_UNITS-1:0] = next_filter_match_status[NUM_UNITS-1:0] | unit_match;
      next_filter_match_status[EXT_MATCH_BIT] = next_filter_match_status[EXT_MATCH_BIT] | ext_match;
      next_frame_accept = next_frame_accept | (|unit_match);
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      filter_match_status <= '0;
      frame_accept        <= 1'b0;
    end else begin
      filter_match_status <= next_filter_match_status;
      frame_accept        <= next_frame_accept;
    end
  end

  // Read data mux; unmapped offsets read zero
  always_comb begin
    next_rdata = '0;
    case (cfg_addr_in)
      OFS_FILTER_EN: next_rdata = 8'(filter_unit_enable);
      OFS_MODE_CFG:  next_rdata = filter_unit_mode_cfg;
      OFS_TYPE_MASK: next_rdata = frame_type_mask;
      OFS_VER_MASK:  next_rdata = {4'h0, frame_version_mask};
      OFS_STATUS:    next_rdata = {3'h0, filter_match_status};
      OFS_AUTO_MODE: next_rdata = auto_mode_control;
      default: ;
    endcase
    for (int k = 0; k < EXT_BYTES; k++) begin
      if (cfg_addr_in == 8'(EXT_BASE + k)) begin
        next_rdata = ext_address[8*k +: 8];
      end
    end
    for (int u = 0; u < NUM_UNITS; u++) begin
      if (cfg_addr_in == 8'(UNIT_BASE + UNIT_STRIDE*u + PAN_LO_OFS)) begin
        next_rdata = pan_id[u][7:0];
      end
      if (cfg_addr_in == 8'(UNIT_BASE + UNIT_STRIDE*u + PAN_HI_OFS)) begin
        next_rdata = pan_id[u][15:8];
      end
      if (cfg_addr_in == 8'(UNIT_BASE + UNIT_STRIDE*u + SHORT_LO_OFS)) begin
        next_rdata = short_addr[u][7:0];
      end
      if (cfg_addr_in == 8'(UNIT_BASE + UNIT_STRIDE*u + SHORT_HI_OFS)) begin
        next_rdata = short_addr[u][15:8];
      end
    end
    next_ack_type = auto_mode_control[FCS_ADAPT_BIT] ? rx_fcs_type_in : checksum_type_setting_in;
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cfg_rdata_out         <= BYTE_RST;
      cfg_rvalid_out        <= 1'b0;
      frame_accept_out      <= 1'b0;
      ack_checksum_type_out <= FCS_TYPE_16;
      ack_length_out        <= ACK_LEN_FCS16;
    end else begin
      cfg_rdata_out         <= cfg_read_in ? next_rdata : cfg_rdata_out;
      cfg_rvalid_out        <= cfg_read_in;
      frame_accept_out      <= next_frame_accept;
      ack_checksum_type_out <= next_ack_type;
      ack_length_out        <= (next_ack_type == FCS_TYPE_16) ? ACK_LEN_FCS16 : ACK_LEN_FCS32;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  status_clear_a: assert property (
    rx_frame_start_irq_in && !rx_hdr_valid_in |=> filter_match_status == '0)
    else $error("match status not cleared at frame start");
  type_refuse_a: assert property (
    rx_hdr_valid_in && !rx_frame_start_irq_in && !frame_type_mask[rx_frame_type_in]
    |=> $stable(filter_match_status) && frame_accept_out == $past(frame_accept))
    else $error("refused frame type produced a match");
  version_refuse_a: assert property (
    rx_hdr_valid_in && !rx_frame_start_irq_in && !frame_version_mask[rx_frame_version_in]
    |=> $stable(filter_match_status) && frame_accept_out == $past(frame_accept))
    else $error("refused frame version produced a match");
  type_reset_a: assert property (
    $rose(resetn_in) |-> frame_type_mask == TYPE_MASK_RST && frame_version_mask == VER_MASK_RST)
    else $error("mask reset values wrong");
  unit_off_a: assert property (
    rx_hdr_valid_in && !filter_unit_enable[0] |-> !unit_match[0])
    else $error("disabled unit raised a match");
  ext_match_a: assert property (
    rx_hdr_valid_in && ext_match |=> filter_match_status[EXT_MATCH_BIT])
    else $error("extended match flag not set");
  ack_hold_a: assert property (
    !(rx_frame_end_irq_in && auto_mode_control[AUTO_ACK_BIT])
    |=> auto_mode_control[ACK_SENT_BIT] == $past(auto_mode_control[ACK_SENT_BIT]))
    else $error("ack sent flag changed outside frame end");
  ack_update_a: assert property (
    rx_frame_end_irq_in && auto_mode_control[AUTO_ACK_BIT]
    |=> auto_mode_control[ACK_SENT_BIT] == $past(frame_accept && rx_ack_request_in))
    else $error("ack sent flag not updated at frame end");
  fcs_adapt_a: assert property (
    auto_mode_control[FCS_ADAPT_BIT] |=> ack_checksum_type_out == $past(rx_fcs_type_in))
    else $error("ack checksum type does not follow received frame");
  fcs_setting_a: assert property (
    !auto_mode_control[FCS_ADAPT_BIT] |=> ack_checksum_type_out == $past(checksum_type_setting_in))
    else $error("ack checksum type does not follow setting");
  ack_len_a: assert property (
    ack_length_out == ((ack_checksum_type_out == FCS_TYPE_16) ? ACK_LEN_FCS16 : ACK_LEN_FCS32))
    else $error("ack length does not match checksum type");

  accept_c: cover property (rx_hdr_valid_in ##1 frame_accept_out);
  ack_sent_c: cover property ($rose(auto_mode_control[ACK_SENT_BIT]));
  reserved_c: cover property (rx_hdr_valid_in && rx_frame_type_in >= FT_RSV_MIN && (|unit_match));
  ext_c: cover property (rx_hdr_valid_in && ext_match);
endmodule
`default_nettype wire

/* verif/rx_frame_source.sv */
// Baseband receiver model delivering decoded frame headers and events
`default_nettype none
module rx_frame_source (
  // Clock
  input  wire logic        mclk_in,
  // Frame events and header fields
  output logic             start_out,
  output logic             hdr_out,
  output logic             end_out,
  output logic      [2:0]  type_out,
  output logic      [1:0]  ver_out,
  output logic      [1:0]  mode_out,
  output logic      [15:0] dpan_out,
  output logic      [15:0] dshort_out,
  output logic      [15:0] span_out,
  output logic      [63:0] dext_out,
  output logic             ack_req_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {start_out, hdr_out, end_out, ack_req_out} = '0;
    {type_out, ver_out, mode_out, dpan_out, dshort_out, span_out, dext_out} = '0;
  end
  task automatic pulse_start();
    @(posedge mclk_in) #2 start_out = 1'b1;
    @(posedge mclk_in) #2 start_out = 1'b0;
  endtask
  // Fields hold only in the header cycle, scrambled otherwise
  task automatic send(input logic [2:0] ft, input logic [1:0] ver, md, input logic [15:0] dp, ds, sp,
                      input logic [63:0] de, input logic ack);
    logic [118:0] f;
    f = {ft, ver, md, dp, ds, sp, de};
    pulse_start();
    {type_out, ver_out, mode_out, dpan_out, dshort_out, span_out, dext_out} = f;
    hdr_out = 1'b1;
    @(posedge mclk_in) #2 hdr_out = 1'b0;
    {type_out, ver_out, mode_out, dpan_out, dshort_out, span_out, dext_out} = ~f;
    {end_out, ack_req_out} = {1'b1, ack};
    @(posedge mclk_in) #2 end_out = 1'b0;
    ack_req_out = ~ack;
  endtask
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking testbench for the frame address filter register bank
`default_nettype none
module tb_top
  import frame_filter_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic [7:0]  addr = '0, wdata = '0, rdata;
  logic        wr_s = 1'b0, rd_s = 1'b0, fcs_rx = 1'b0, fcs_set = 1'b1;
  logic        rvalid, accept, ack_type, fst, fhdr, fend, fack;
  logic [2:0]  ack_len, ftype;
  logic [1:0]  fver, fmode;
  logic [15:0] dpan, dshort, span;
  logic [63:0] dext;
  int          n_mismatch = 0;
  int          num_checks = 0;
  localparam logic [63:0] EXT = 64'h1716151413121110;
  localparam logic [23:0] ROWS [9] = '{24'h01a5a5, 24'h025a5a, 24'h03ff0f, 24'h04ff00, 24'h1dff7b,
                                      24'h051111, 24'h0c8888, 24'h0d3434, 24'h1e7700};
  always #12.5 mclk_in = ~mclk_in;
  frame_address_filter_regs i_dut (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .cfg_addr_in(addr), .cfg_wdata_in(wdata),
    .cfg_write_in(wr_s), .cfg_read_in(rd_s), .cfg_rdata_out(rdata), .cfg_rvalid_out(rvalid),
    .rx_frame_start_irq_in(fst), .rx_hdr_valid_in(fhdr), .rx_frame_end_irq_in(fend),
    .rx_frame_type_in(ftype), .rx_frame_version_in(fver), .rx_dst_mode_in(fmode),
    .rx_dst_pan_in(dpan), .rx_dst_short_in(dshort), .rx_dst_ext_in(dext), .rx_src_pan_in(span),
    .rx_ack_request_in(fack), .rx_fcs_type_in(fcs_rx), .checksum_type_setting_in(fcs_set),
    .frame_accept_out(accept), .ack_checksum_type_out(ack_type), .ack_length_out(ack_len));
  rx_frame_source i_src (
    .mclk_in(mclk_in), .start_out(fst), .hdr_out(fhdr), .end_out(fend), .type_out(ftype),
    .ver_out(fver), .mode_out(fmode), .dpan_out(dpan), .dshort_out(dshort), .span_out(span),
    .dext_out(dext), .ack_req_out(fack));
  task automatic chk(input string nm, input logic [7:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge mclk_in) #2 {addr, wdata, wr_s} = {a, d, 1'b1};
    @(posedge mclk_in) #2 wr_s = 1'b0;
  endtask
  task automatic rd(input string nm, input logic [7:0] a, exp);
    @(posedge mclk_in) #2 {addr, rd_s} = {a, 1'b1};
    @(posedge mclk_in) #2 rd_s = 1'b0;
    chk("read valid", 8'h01, {7'h0, rvalid});
    chk(nm, exp, rdata);
  endtask
  task automatic uframe(input logic [2:0] ft, input logic [1:0] ver, input int u, input logic ack);
    i_src.send(ft, ver, AM_SHORT, {8'h12, 8'(u)}, {8'hab, 8'(u)}, 16'h0, 64'h0, ack);
  endtask
  task automatic ackchk(input logic [7:0] am, input logic s, r, e);
    {fcs_set, fcs_rx} = {s, r};
    wr(OFS_AUTO_MODE, am);
    @(posedge mclk_in) #2;
    chk("ack type", {7'h0, e}, {7'h0, ack_type});
    chk("ack length", e ? 8'h05 : 8'h07, {5'h0, ack_len});
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #200us;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge mclk_in);
    #2 resetn_in = 1'b1;
    foreach (ROWS[i]) begin
      wr(ROWS[i][23:16], ROWS[i][15:8]);
      rd("row readback", ROWS[i][23:16], ROWS[i][7:0]);
    end
    rd("type mask set", OFS_TYPE_MASK, 8'h5a);
    fcs_set = 1'b0;
    $display("test register access done");
    // Second reset in mid-run; outputs checked while it is held
    @(posedge mclk_in) #2 resetn_in = 1'b0;
    @(negedge mclk_in);
    chk("reset rdata", 8'h00, rdata);
    chk("reset rvalid", 8'h00, {7'h0, rvalid});
    chk("reset accept", 8'h00, {7'h0, accept});
    chk("reset ack type", 8'h01, {7'h0, ack_type});
    chk("reset ack length", 8'h05, {5'h0, ack_len});
    @(posedge mclk_in) #2 {resetn_in, fcs_set} = 2'b11;
    rd("type mask", OFS_TYPE_MASK, 8'h0b);
    rd("version mask", OFS_VER_MASK, 8'h03);
    rd("mode cfg", OFS_MODE_CFG, 8'h00);
    rd("auto mode", OFS_AUTO_MODE, 8'h00);
    rd("ext byte7", 8'h0c, 8'h00);
    $display("test reset values done");
    wr(OFS_FILTER_EN, 8'h0f);
    for (int u = 0; u < 4; u++) begin
      wr(8'h0d + 8'(4 * u), 8'(u));
      wr(8'h0e + 8'(4 * u), 8'h12);
      wr(8'h0f + 8'(4 * u), 8'(u));
      wr(8'h10 + 8'(4 * u), 8'hab);
    end
    for (int u = 0; u < 4; u++) begin
      uframe(FT_DATA, 2'h0, u, 1'b0);
      rd("unit status", OFS_STATUS, 8'h01 << u);
      chk("accept", 8'h01, {7'h0, accept});
    end
    uframe(3'h2, 2'h0, 0, 1'b0);
    rd("type refused", OFS_STATUS, 8'h00);
    chk("refused accept", 8'h00, {7'h0, accept});
    uframe(FT_DATA, 2'h2, 0, 1'b0);
    rd("version refused", OFS_STATUS, 8'h00);
    uframe(FT_DATA, 2'h1, 0, 1'b0);
    rd("version one", OFS_STATUS, 8'h01);
    i_src.pulse_start();
    rd("start clear", OFS_STATUS, 8'h00);
    wr(OFS_TYPE_MASK, 8'hff);
    uframe(3'h7, 2'h0, 0, 1'b0);
    rd("reserved dropped", OFS_STATUS, 8'h00);
    wr(OFS_MODE_CFG, 8'h10);
    uframe(3'h7, 2'h0, 0, 1'b0);
    rd("reserved mapped", OFS_STATUS, 8'h01);
    $display("test type and version done");
    i_src.send(FT_DATA, 2'h0, AM_NONE, 16'h0, 16'h0, 16'h1200, 64'h0, 1'b0);
    rd("no coordinator", OFS_STATUS, 8'h00);
    wr(OFS_MODE_CFG, 8'h01);
    i_src.send(FT_DATA, 2'h0, AM_NONE, 16'h0, 16'h0, 16'h1200, 64'h0, 1'b0);
    rd("coordinator", OFS_STATUS, 8'h01);
    i_src.send(FT_BEACON, 2'h0, AM_NONE, 16'h0, 16'h0, 16'h1201, 64'h0, 1'b0);
    rd("beacon", OFS_STATUS, 8'h02);
    for (int k = 0; k < 8; k++) wr(8'h05 + 8'(k), EXT[8*k +: 8]);
    i_src.send(FT_DATA, 2'h0, AM_EXT, 16'h1200, 16'h0, 16'h0, EXT, 1'b0);
    rd("ext match", OFS_STATUS, 8'h11);
    wr(OFS_FILTER_EN, 8'h00);
    i_src.send(FT_DATA, 2'h0, AM_EXT, 16'h1200, 16'h0, 16'h0, EXT, 1'b0);
    rd("all disabled", OFS_STATUS, 8'h00);
    wr(OFS_FILTER_EN, 8'h01);
    uframe(FT_DATA, 2'h0, 1, 1'b0);
    rd("unit disabled", OFS_STATUS, 8'h00);
    $display("test address match done");
    wr(OFS_AUTO_MODE, 8'h08);
    uframe(FT_DATA, 2'h0, 0, 1'b1);
    rd("ack sent", OFS_AUTO_MODE, 8'h88);
    wr(OFS_AUTO_MODE, 8'h00);
    uframe(FT_DATA, 2'h0, 1, 1'b0);
    rd("ack flag held", OFS_AUTO_MODE, 8'h80);
    wr(OFS_AUTO_MODE, 8'h08);
    uframe(FT_DATA, 2'h0, 1, 1'b1);
    rd("no ack", OFS_AUTO_MODE, 8'h08);
    ackchk(8'h00, 1'b0, 1'b1, 1'b0);
    ackchk(8'h00, 1'b1, 1'b0, 1'b1);
    ackchk(8'h40, 1'b0, 1'b1, 1'b1);
    ackchk(8'h40, 1'b1, 1'b0, 1'b0);
    $display("test acknowledge done");
    end_of_test();
  end
endmodule
`default_nettype wire
